/* inc/rrag_defines.svh */
`ifndef RRAG_DEFINES_SVH
`define RRAG_DEFINES_SVH

// one general register is 32 bytes, so its number sits above bit 4
`define RRAG_REG_SHIFT          5

// row step code that turns a source into a per-row or per-element index
`define RRAG_ROW_STEP_INDIRECT  4'hF

// index register layout: register number in 15:5, byte offset in 4:0
`define RRAG_IDX_W              16
`define RRAG_IDX_REG_MSB        15
`define RRAG_IDX_REG_LSB        5
`define RRAG_IDX_OFF_MSB        4
`define RRAG_IDX_RESET          16'h0000

// element size as a left shift of the element count
`define RRAG_ESZ_SHIFT_BYTE     2'h0
`define RRAG_ESZ_SHIFT_WORD     2'h1
`define RRAG_ESZ_SHIFT_DWORD    2'h2

// registers a region may touch
`define RRAG_DIRECT_MAX_SPAN    2
`define RRAG_DST_MAX_SPAN       1

`endif

/* inc/rrag_pkg.sv */
package rrag_pkg;

  // element types of an operand
  typedef enum logic [2:0] {
    RRAG_UB,
    RRAG_B,
    RRAG_UW,
    RRAG_W,
    RRAG_UD,
    RRAG_D,
    RRAG_F,
    RRAG_V
  } rrag_elem_type_t;

  // resolved addressing form of an operand
  typedef enum logic [1:0] {
    RRAG_DIRECT,
    RRAG_ORIGIN_INDEXED,
    RRAG_ROW_INDEXED,
    RRAG_ELEMENT_INDEXED
  } rrag_region_t;

endpackage

/* rtl/rrag_index_file.sv */
`include "rrag_defines.svh"

module rrag_index_file #(
  parameter int NUM   = 16,
  parameter int SEL_W = 4
)(
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        wr_en,
  input  wire logic [SEL_W-1:0]            wr_sel,
  input  wire logic [`RRAG_IDX_W-1:0]      wr_data,
  output logic      [NUM*`RRAG_IDX_W-1:0]  contents
);

  ////////////////////////////////////////////////////////////////////////////
  // every entry is a register and is read out in parallel
  always_ff @(posedge clock)
  begin
    if (!rstn)
      contents <= {NUM{`RRAG_IDX_RESET}};
    else if (wr_en)
      contents[wr_sel*`RRAG_IDX_W +: `RRAG_IDX_W] <= wr_data;
  end

endmodule

/* rtl/rrag_region_address_gen.sv */
// Functional notes
// RQ1 - byte 1, word 2, others 4 bytes
// RQ2 - origin is register times 32 plus subelement
// RQ3 - rows equal channel count over width
// RQ4 - element and row steps scale by size
// RQ5 - row step below element step is allowed
// RQ6 - zero steps are legal
// RQ7 - destination is one row, element step only
// RQ8 - destination stays within one register
// RQ9 - multi register sources report gather span
// RQ10 - direct plus three indirect forms
// RQ11 - direct takes everything from instruction fields
// RQ12 - origin indexed takes origin from index
// RQ13 - row indexed takes each row origin
// RQ14 - index bits 15:5 register, 4:0 byte
// RQ15 - row step code 0xF selects indexed rows
// RQ16 - element indexed uses one index per channel
// RQ17 - channel count sizes source and destination
// RQ18 - direct source spans at most two registers
// RQ19 - addresses valid the cycle after decode
// RQ20 - illegal regions flagged, never hang
`include "rrag_defines.svh"

module rrag_region_address_gen #(
  parameter int MAX_CH    = 16,
  parameter int CH_LOG_W  = 3,
  parameter int NUM_IDX   = 16,
  parameter int IDX_SEL_W = 4,
  parameter int REG_W     = 8,
  parameter int ADDR_W    = 16
)(
  input  wire logic                            clock,
  input  wire logic                            rstn,
  input  wire logic                            decode_valid,
  input  wire logic                            dst_sel,
  input  wire logic                            indirect_sel,
  input  wire rrag_pkg::rrag_elem_type_t       elem_type,
  input  wire logic [REG_W-1:0]                register_index,
  input  wire logic [4:0]                      sub_element_index,
  input  wire logic [CH_LOG_W-1:0]             channel_count_log,
  input  wire logic [CH_LOG_W-1:0]             width_log,
  input  wire logic [3:0]                      row_step_code,
  input  wire logic [1:0]                      element_step_code,
  input  wire logic [IDX_SEL_W-1:0]            first_index_register,
  input  wire logic                            idx_wr_en,
  input  wire logic [IDX_SEL_W-1:0]            idx_wr_sel,
  input  wire logic [`RRAG_IDX_W-1:0]          idx_wr_data,
  output logic                                 addr_valid,
  output logic      [MAX_CH*ADDR_W-1:0]        chan_addr,
  output logic      [MAX_CH-1:0]               lane_active,
  output rrag_pkg::rrag_region_t               region_kind,
  output logic      [ADDR_W-1:0]               reg_span,
  output logic                                 multi_reg_gather,
  output logic                                 illegal_region
);

  localparam int CH_LOG_MAX = $clog2(MAX_CH);

  ////////////////////////////////////////////////////////////////////////////
  // parameter sanity
  generate
    if (MAX_CH != (1 << CH_LOG_MAX) || NUM_IDX != (1 << IDX_SEL_W) ||
        ADDR_W < REG_W + `RRAG_REG_SHIFT || ADDR_W < `RRAG_IDX_W ||
        (1 << CH_LOG_W) <= CH_LOG_MAX)
    begin : g_bad_params
      $error("rrag: unsupported parameter set");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // element size as a shift amount
  function automatic logic [1:0] esz_shift(rrag_pkg::rrag_elem_type_t t);
    case (t)
      rrag_pkg::RRAG_UB, rrag_pkg::RRAG_B:
        esz_shift = `RRAG_ESZ_SHIFT_BYTE;
      rrag_pkg::RRAG_UW, rrag_pkg::RRAG_W:
        esz_shift = `RRAG_ESZ_SHIFT_WORD;
      default:
        esz_shift = `RRAG_ESZ_SHIFT_DWORD;
    endcase
  endfunction

  // row step code: 0 is zero, n gives 2^(n-1) elements
  function automatic logic [ADDR_W-1:0] row_step_elems(logic [3:0] c);
    if (c == 4'h0)
      row_step_elems = '0;
    else
      row_step_elems = ADDR_W'(1) << (c - 4'h1);
  endfunction

  // element step code: 0 is zero, n gives 2^(n-1) elements
  function automatic logic [ADDR_W-1:0] elem_step_elems(logic [1:0] c);
    if (c == 2'h0)
      elem_step_elems = '0;
    else
      elem_step_elems = ADDR_W'(1) << (c - 2'h1);
  endfunction

  // index register value to byte address
  function automatic logic [ADDR_W-1:0] idx_to_addr(
    logic [`RRAG_IDX_W-1:0] v
  );
    logic [`RRAG_IDX_W-1:0] regbase;
    regbase = {v[`RRAG_IDX_REG_MSB:`RRAG_IDX_REG_LSB],
               `RRAG_REG_SHIFT'(0)};
    idx_to_addr = ADDR_W'(regbase) + ADDR_W'(v[`RRAG_IDX_OFF_MSB:0]);
  endfunction

  // pick one index register from the flat bank
  function automatic logic [`RRAG_IDX_W-1:0] idx_pick(
    logic [NUM_IDX*`RRAG_IDX_W-1:0] bank,
    logic [IDX_SEL_W-1:0]           sel
  );
    idx_pick = bank[sel*`RRAG_IDX_W +: `RRAG_IDX_W];
  endfunction

  // one lane address out of a flat vector
  function automatic logic [ADDR_W-1:0] lane(
    logic [MAX_CH*ADDR_W-1:0] vec,
    int                       k
  );
    lane = vec[k*ADDR_W +: ADDR_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // index register bank
  logic [NUM_IDX*`RRAG_IDX_W-1:0] idx_all;

  rrag_index_file #(
    .NUM   (NUM_IDX),
    .SEL_W (IDX_SEL_W)
  ) u_index_file (
    .clock    (clock),
    .rstn     (rstn),
    .wr_en    (idx_wr_en),
    .wr_sel   (idx_wr_sel),
    .wr_data  (idx_wr_data),
    .contents (idx_all)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operand decode
  wire [1:0]                   shift;
  wire                         step_is_ind;
  wire rrag_pkg::rrag_region_t kind;
  wire [CH_LOG_W-1:0]          clog_eff;
  wire [CH_LOG_W-1:0]          wlog_eff;
  wire [CH_LOG_W-1:0]          rlog;
  wire [ADDR_W-1:0]            count;
  wire [ADDR_W-1:0]            rows;
  wire [ADDR_W-1:0]            direct_origin;
  wire [ADDR_W-1:0]            start_addr;
  wire [ADDR_W-1:0]            row_stride;
  wire [ADDR_W-1:0]            elem_stride;

  // RQ1 element size
  assign shift = esz_shift(elem_type);
  // RQ15 escape code
  assign step_is_ind = row_step_code == `RRAG_ROW_STEP_INDIRECT;
  // RQ10 addressing form
  assign kind = !indirect_sel ? rrag_pkg::RRAG_DIRECT :
                (step_is_ind && !dst_sel) ?
                  ((width_log == '0) ? rrag_pkg::RRAG_ELEMENT_INDEXED :
                                       rrag_pkg::RRAG_ROW_INDEXED) :
                rrag_pkg::RRAG_ORIGIN_INDEXED;
  // RQ17 one count for all
  assign clog_eff = (channel_count_log > CH_LOG_W'(CH_LOG_MAX)) ?
                    CH_LOG_W'(CH_LOG_MAX) : channel_count_log;
  // RQ7 destination is one row
  assign wlog_eff = (dst_sel || width_log > clog_eff) ? clog_eff : width_log;
  // RQ3 rows from count
  assign rlog  = clog_eff - wlog_eff;
  assign count = ADDR_W'(1) << clog_eff;
  assign rows  = ADDR_W'(1) << rlog;
  // RQ2 origin address
  assign direct_origin = ADDR_W'({register_index, `RRAG_REG_SHIFT'(0)}) +
                         (ADDR_W'(sub_element_index) << shift);
  // RQ12 origin from index
  assign start_addr = (kind == rrag_pkg::RRAG_ORIGIN_INDEXED) ?
                      idx_to_addr(idx_pick(idx_all, first_index_register)) :
                      direct_origin;
  // RQ4 byte strides
  assign row_stride  = row_step_elems(row_step_code) << shift;
  assign elem_stride = elem_step_elems(element_step_code) << shift;

  ////////////////////////////////////////////////////////////////////////////
  // per channel address, row major
  logic [MAX_CH*ADDR_W-1:0] next_addr;
  logic [MAX_CH-1:0]        next_active;

  genvar ch;
  generate
    for (ch = 0; ch < MAX_CH; ch++)
    begin : g_lane
      localparam logic [ADDR_W-1:0] CH = ADDR_W'(ch);
      wire [ADDR_W-1:0]    row;
      wire [ADDR_W-1:0]    col;
      wire [IDX_SEL_W-1:0] isel;
      wire [ADDR_W-1:0]    ibase;
      wire [ADDR_W-1:0]    base;
      // RQ3 row and column
      assign row  = CH >> wlog_eff;
      assign col  = CH - (row << wlog_eff);
      // RQ13 RQ16 index register per row or element
      assign isel = first_index_register + IDX_SEL_W'(
                    (kind == rrag_pkg::RRAG_ELEMENT_INDEXED) ? CH : row);
      // RQ14 index decode
      assign ibase = idx_to_addr(idx_pick(idx_all, isel));
      // RQ4 RQ5 RQ6 row base, any step allowed
      assign base = (kind == rrag_pkg::RRAG_ROW_INDEXED ||
                     kind == rrag_pkg::RRAG_ELEMENT_INDEXED) ? ibase :
                    start_addr + ADDR_W'(row * row_stride);
      // RQ4 RQ11 step within the row
      assign next_addr[ch*ADDR_W +: ADDR_W] =
             base + ADDR_W'(col * elem_stride);
      // RQ17 active lanes
      assign next_active[ch] = CH < count;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register span of the active lanes
  logic [ADDR_W-1:0] next_span;

  // RQ9 gather span
  always_comb
  begin
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
    logic [ADDR_W-1:0] r;
    lo = '1;
    hi = '0;
    r  = '0;
    for (int k = 0; k < MAX_CH; k++)
    begin
      if (next_active[k])
      begin
        r = lane(next_addr, k) >> `RRAG_REG_SHIFT;
        if (r < lo)
          lo = r;
        if (r > hi)
          hi = r;
      end
    end
    next_span = hi - lo + ADDR_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // legality checks
  wire [ADDR_W-1:0] idx_used;
  wire              idx_overflow;
  wire              bad_code;
  wire              bad_width;
  wire              bad_span;
  wire              next_illegal;

  assign idx_used = (kind == rrag_pkg::RRAG_ELEMENT_INDEXED) ? count :
                    (kind == rrag_pkg::RRAG_ROW_INDEXED)     ? rows  :
                    (kind == rrag_pkg::RRAG_ORIGIN_INDEXED)  ?
                      ADDR_W'(1) : '0;
  assign idx_overflow = ADDR_W'(first_index_register) + idx_used >
                        ADDR_W'(NUM_IDX);
  assign bad_code  = (!indirect_sel && step_is_ind && !dst_sel) ||
                     channel_count_log > CH_LOG_W'(CH_LOG_MAX);
  // RQ3 width above count
  assign bad_width = !dst_sel && width_log > channel_count_log;
  // RQ8 RQ18 span limits
  assign bad_span  = (dst_sel && next_span > ADDR_W'(`RRAG_DST_MAX_SPAN)) ||
                     (kind == rrag_pkg::RRAG_DIRECT && !dst_sel &&
                      next_span > ADDR_W'(`RRAG_DIRECT_MAX_SPAN));
  // RQ20 flag only, never stall
  assign next_illegal = bad_code || bad_width || bad_span || idx_overflow;

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  // RQ19 one cycle after decode
  always_ff @(posedge clock)
  begin
    if (!rstn)
      addr_valid <= 1'b0;
    else
      addr_valid <= decode_valid;
  end

  // results held until the next decode
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      chan_addr        <= '0;
      lane_active      <= '0;
      region_kind      <= rrag_pkg::RRAG_DIRECT;
      reg_span         <= '0;
      multi_reg_gather <= 1'b0;
      illegal_region   <= 1'b0;
    end
    else if (decode_valid)
    begin
      chan_addr        <= next_addr;
      lane_active      <= next_active;
      region_kind      <= kind;
      reg_span         <= next_span;
      multi_reg_gather <= next_span > ADDR_W'(1);
      illegal_region   <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_valid_next;
    @(posedge clock) disable iff (!rstn)
    decode_valid |=> addr_valid ##1 (addr_valid == $past(decode_valid));
  endproperty
  a_valid_next: assert property (p_valid_next) // RQ19
    else $error("valid did not follow decode");

  property p_byte_origin;
    @(posedge clock) disable iff (!rstn)
    decode_valid && !indirect_sel && elem_type == rrag_pkg::RRAG_B |=>
      lane(chan_addr, 0) ==
      ADDR_W'({$past(register_index), `RRAG_REG_SHIFT'(0)}) +
      ADDR_W'($past(sub_element_index));
  endproperty
  a_byte_origin: assert property (p_byte_origin) // RQ1
    else $error("byte origin wrong");

  property p_origin;
    @(posedge clock) disable iff (!rstn)
    decode_valid && !indirect_sel |=>
      lane(chan_addr, 0) ==
      ADDR_W'({$past(register_index), `RRAG_REG_SHIFT'(0)}) +
      (ADDR_W'($past(sub_element_index)) << esz_shift($past(elem_type)));
  endproperty
  a_origin: assert property (p_origin) // RQ2
    else $error("direct origin wrong");

  property p_elem_step;
    @(posedge clock) disable iff (!rstn)
    decode_valid && wlog_eff != '0 && kind != rrag_pkg::RRAG_ROW_INDEXED |=>
      lane(chan_addr, 1) - lane(chan_addr, 0) ==
      (elem_step_elems($past(element_step_code)) <<
       esz_shift($past(elem_type)));
  endproperty
  a_elem_step: assert property (p_elem_step) // RQ4
    else $error("element step wrong");

  property p_row_step;
    @(posedge clock) disable iff (!rstn)
    decode_valid && !indirect_sel && !dst_sel && rlog != '0 |=>
      lane(chan_addr, 32'(1) << $past(wlog_eff)) - lane(chan_addr, 0) ==
      (row_step_elems($past(row_step_code)) << esz_shift($past(elem_type)));
  endproperty
  a_row_step: assert property (p_row_step) // RQ5
    else $error("row step wrong");

  property p_dst_lanes;
    @(posedge clock) disable iff (!rstn)
    decode_valid && dst_sel |=> lane_active ==
      MAX_CH'((64'h1 << (32'(1) << $past(clog_eff))) - 64'h1) &&
      reg_span != '0;
  endproperty
  a_dst_lanes: assert property (p_dst_lanes) // RQ17
    else $error("lane count wrong");

  property p_dst_span;
    @(posedge clock) disable iff (!rstn)
    decode_valid && dst_sel |=>
      (reg_span <= ADDR_W'(`RRAG_DST_MAX_SPAN)) || illegal_region;
  endproperty
  a_dst_span: assert property (p_dst_span) // RQ8
    else $error("destination crosses register unflagged");

  property p_src_span;
    @(posedge clock) disable iff (!rstn)
    decode_valid && !indirect_sel && !dst_sel |=>
      (reg_span <= ADDR_W'(`RRAG_DIRECT_MAX_SPAN)) || illegal_region;
  endproperty
  a_src_span: assert property (p_src_span) // RQ18
    else $error("direct source span unflagged");

  property p_origin_idx;
    @(posedge clock) disable iff (!rstn)
    decode_valid && kind == rrag_pkg::RRAG_ORIGIN_INDEXED |=>
      lane(chan_addr, 0) ==
      idx_to_addr(idx_pick($past(idx_all), $past(first_index_register)));
  endproperty
  a_origin_idx: assert property (p_origin_idx) // RQ12
    else $error("indexed origin wrong");

  property p_row_idx;
    @(posedge clock) disable iff (!rstn)
    decode_valid && kind == rrag_pkg::RRAG_ROW_INDEXED && rlog != '0 |=>
      lane(chan_addr, 32'(1) << $past(wlog_eff)) ==
      idx_to_addr(idx_pick($past(idx_all),
        IDX_SEL_W'($past(first_index_register) + IDX_SEL_W'(1))));
  endproperty
  a_row_idx: assert property (p_row_idx) // RQ13
    else $error("second row origin wrong");

  property p_elem_idx;
    @(posedge clock) disable iff (!rstn)
    decode_valid && kind == rrag_pkg::RRAG_ELEMENT_INDEXED &&
      clog_eff != '0 |=>
      lane(chan_addr, 1) == idx_to_addr(idx_pick($past(idx_all),
        IDX_SEL_W'($past(first_index_register) + IDX_SEL_W'(1))));
  endproperty
  a_elem_idx: assert property (p_elem_idx) // RQ16
    else $error("second element index wrong");

  property p_width_flag;
    @(posedge clock) disable iff (!rstn)
    decode_valid && !dst_sel && width_log > channel_count_log |=>
      illegal_region && addr_valid;
  endproperty
  a_width_flag: assert property (p_width_flag) // RQ20
    else $error("width above count unflagged");

endmodule

/* verif/rrag_fetch_model.sv */
////////////////////////////////////////////////////////////////////////
// operand fetch stage: takes each address set and checks its timing
module rrag_fetch_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic decode_valid,
  input  wire logic addr_valid,
  output int        fetches,
  output logic      late
);
  timeunit 1ns;
  timeprecision 100ps;

  logic pending;

  // nothing fetched or flagged before the first edge
  initial
  begin
    fetches = 0;
    late = 1'b0;
    pending = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // expect an address set exactly one edge after every taken decode
  // valid after decode
  always @(posedge clock)
  begin
    if (addr_valid === 1'b1)
      fetches <= fetches + 1;
    if (!rstn)
      pending <= 1'b0;
    else
    begin
      pending <= decode_valid;
      if (addr_valid !== pending)
        late <= 1'b1;
    end
  end
endmodule

/* verif/rrag_region_address_gen_tb.sv */
module rrag_region_address_gen_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                       clock;
  logic                       rstn;
  logic                       decode_valid;
  logic                       dst_sel;
  logic                       indirect_sel;
  rrag_pkg::rrag_elem_type_t  elem_type;
  logic [7:0]                 register_index;
  logic [4:0]                 sub_element_index;
  logic [2:0]                 channel_count_log;
  logic [2:0]                 width_log;
  logic [3:0]                 row_step_code;
  logic [1:0]                 element_step_code;
  logic [3:0]                 first_index_register;
  logic                       idx_wr_en;
  logic [3:0]                 idx_wr_sel;
  logic [15:0]                idx_wr_data;
  logic                       addr_valid;
  logic [255:0]               chan_addr;
  logic [15:0]                lane_active;
  rrag_pkg::rrag_region_t     region_kind;
  logic [15:0]                reg_span;
  logic                       multi_reg_gather;
  logic                       illegal_region;
  int                         fetches;
  logic                       late;
  logic [15:0]                idx_bank [16];
  int                         failures = 0;
  int                         check_count = 0;
  int                         ops = 0;

  rrag_region_address_gen dut (.clock, .rstn, .decode_valid, .dst_sel,
    .indirect_sel, .elem_type, .register_index, .sub_element_index,
    .channel_count_log, .width_log, .row_step_code, .element_step_code,
    .first_index_register, .idx_wr_en, .idx_wr_sel, .idx_wr_data,
    .addr_valid, .chan_addr, .lane_active, .region_kind, .reg_span,
    .multi_reg_gather, .illegal_region);

  rrag_fetch_model fetch (.clock, .rstn, .decode_valid, .addr_valid,
    .fetches, .late);

  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // expectation helpers
  // element size
  function automatic int esz(rrag_pkg::rrag_elem_type_t t);
    if (t == rrag_pkg::RRAG_UB || t == rrag_pkg::RRAG_B)
      return 1;
    if (t == rrag_pkg::RRAG_UW || t == rrag_pkg::RRAG_W)
      return 2;
    return 4;
  endfunction

  // step code to elements
  function automatic int stp(int c);
    return (c == 0) ? 0 : 1 << (c - 1);
  endfunction

  // byte address of lane k for the fields now driven
  function automatic int lane_addr(int k);
    int s, es, rs, row, col, org;
    s = esz(elem_type);
    es = stp(element_step_code) * s;
    rs = stp(row_step_code) * s;
    row = k >> width_log;
    col = k - (row << width_log);
    org = indirect_sel ? int'(idx_bank[first_index_register])
        : register_index * 32 + sub_element_index * s;
    if (dst_sel)
      return (org + k * es) & 'hFFFF;
    if (indirect_sel && row_step_code == 4'hF)
    begin
      if (width_log == 0)
        return idx_bank[(first_index_register + k) % 16];
      return (idx_bank[(first_index_register + row) % 16] + col * es)
             & 'hFFFF;
    end
    return (org + row * rs + col * es) & 'hFFFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string name, input logic [255:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // verdict and stop
  task automatic end_of_test();
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one decode, optional index write in the same cycle
  task automatic op(input int d, ind, t, rg, sb, cl, wl, rs, es, fi, we,
                    ws, wd);
    logic [255:0] ea, mk;
    logic [15:0]  m;
    int           n, lo, hi, a, ill, sp;
    rrag_pkg::rrag_region_t k;
    decode_valid = 1'b1;
    dst_sel = d[0];
    indirect_sel = ind[0];
    elem_type = rrag_pkg::rrag_elem_type_t'(t[2:0]);
    register_index = rg[7:0];
    sub_element_index = sb[4:0];
    channel_count_log = cl[2:0];
    width_log = wl[2:0];
    row_step_code = rs[3:0];
    element_step_code = es[1:0];
    first_index_register = fi[3:0];
    idx_wr_en = we[0];
    idx_wr_sel = ws[3:0];
    idx_wr_data = wd[15:0];
    n = (cl > 4) ? 16 : 1 << cl;
    k = !ind ? rrag_pkg::RRAG_DIRECT : (d || rs != 15) ?
        rrag_pkg::RRAG_ORIGIN_INDEXED : (wl == 0) ?
        rrag_pkg::RRAG_ELEMENT_INDEXED : rrag_pkg::RRAG_ROW_INDEXED;
    lo = 1 << 30;
    hi = 0;
    ea = '0;
    mk = '0;
    m = '0;
    for (int i = 0; i < n; i++)
    begin
      a = lane_addr(i);
      ea[i*16 +: 16] = a[15:0];
      mk[i*16 +: 16] = 16'hFFFF;
      m[i] = 1'b1;
      lo = (a >> 5 < lo) ? a >> 5 : lo;
      hi = (a >> 5 > hi) ? a >> 5 : hi;
    end
    sp = hi - lo + 1;
    ill = (cl > 4) || (!d && wl > cl) || (!ind && !d && rs == 15)
       || (d && sp > 1) || (!ind && !d && sp > 2)
       || (k == rrag_pkg::RRAG_ROW_INDEXED && fi + (n >> wl) > 16)
       || (k == rrag_pkg::RRAG_ELEMENT_INDEXED && fi + n > 16);
    if (we)
      idx_bank[ws] = wd[15:0];
    ops++;
    @(negedge clock);
    chk("addr_valid", addr_valid, 1);
    chk("illegal_region", illegal_region, ill);
    if (!ill)
    begin
      chk("lane_active", lane_active, m);
      chk("region_kind", region_kind, k);
      chk("reg_span", reg_span, sp);
      chk("multi_reg_gather", multi_reg_gather, sp > 1);
      chk("chan_addr", chan_addr & mk, ea);
    end
  endtask

  // a cycle without decode
  task automatic idle();
    decode_valid = 1'b0;
    idx_wr_en = 1'b0;
    @(negedge clock);
    chk("addr_valid", addr_valid, 0);
  endtask

  // reset held four cycles with a decode pending
  task automatic do_reset();
    rstn = 1'b0;
    decode_valid = 1'b1;
    idx_wr_en = 1'b0;
    repeat (4) @(negedge clock);
    chk("reset addr_valid", addr_valid, 0);
    chk("reset region_kind", region_kind, rrag_pkg::RRAG_DIRECT);
    chk("reset chan_addr", chan_addr, 0);
    rstn = 1'b1;
    foreach (idx_bank[i])
      idx_bank[i] = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int kd, cl, wl, rs;
    dst_sel = 1'b0;
    indirect_sel = 1'b0;
    elem_type = rrag_pkg::RRAG_UB;
    register_index = '0;
    sub_element_index = '0;
    channel_count_log = '0;
    width_log = '0;
    row_step_code = '0;
    element_step_code = '0;
    first_index_register = '0;
    idx_wr_sel = '0;
    idx_wr_data = '0;
    void'($urandom(14));
    do_reset();
    idle();
    // load the bank; each decode still sees the old value
    for (int i = 0; i < 16; i++)
      op(0, 1, 4, 0, 0, 2, 1, 1, 1, i, 1, i, i * 100 + 4);
    for (int i = 0; i < 16; i++)
      op(0, 1, 4, 0, 0, 2, 1, 1, 1, i, 0, 0, 0);
    for (int t = 0; t < 8; t++)
      op(0, 0, t, 3, 5, 2, 1, 1, 1, 0, 0, 0, 0);
    op(0, 0, 3, 5, 0, 4, 3, 1, 2, 0, 0, 0, 0);
    op(0, 0, 1, 1, 7, 4, 3, 5, 1, 0, 0, 0, 0);
    op(0, 0, 1, 1, 14, 4, 3, 5, 0, 0, 0, 0, 0);
    op(0, 0, 5, 2, 3, 3, 0, 0, 0, 0, 0, 0, 0);
    op(1, 0, 3, 6, 0, 3, 0, 9, 1, 0, 0, 0, 0);
    op(1, 0, 5, 6, 0, 4, 0, 0, 2, 0, 0, 0, 0);
    op(0, 0, 5, 0, 0, 4, 0, 4, 1, 0, 0, 0, 0);
    op(0, 0, 2, 0, 0, 3, 1, 15, 1, 0, 0, 0, 0);
    op(0, 0, 0, 0, 0, 5, 0, 0, 0, 0, 0, 0, 0);
    op(0, 1, 3, 0, 0, 3, 2, 15, 1, 14, 0, 0, 0);
    op(0, 1, 3, 0, 0, 3, 2, 15, 1, 15, 0, 0, 0);
    op(0, 1, 4, 0, 0, 3, 0, 15, 0, 8, 0, 0, 0);
    op(0, 1, 4, 0, 0, 3, 0, 15, 0, 9, 0, 0, 0);
    // random mix of all forms, back to back and spaced
    for (int i = 0; i < 200; i++)
    begin
      kd = $urandom % 4;
      cl = $urandom % 5;
      wl = (kd == 3) ? 0 : $urandom % (cl + 1);
      rs = (kd >= 2) ? 15 : $urandom % 8;
      op($urandom % 4 == 0, kd != 0, $urandom % 8, $urandom % 256,
         $urandom % 8, cl, wl, rs, $urandom % 4, $urandom % 16,
         $urandom % 2, $urandom % 16, $urandom & 'h1FFC);
      if ($urandom % 4 == 0)
        idle();
    end
    do_reset();
    op(0, 1, 4, 0, 0, 2, 1, 1, 1, 3, 0, 0, 0);
    idle();
    chk("fetch_late", late, 0);
    chk("fetches", fetches, ops);
    end_of_test();
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
